// >>> verilog/crt_pkg.sv
// Package for the coprocessor register transfer sequencer.
// Assumes a single core clock.
package crt_pkg;

    // ========================================================================
    // Handshake encoding, same for decode and execute stages
    // ========================================================================
    typedef enum logic [1:0]
    {
        CRT_HS_ABSENT = 2'h0,
        CRT_HS_WAIT   = 2'h1,
        CRT_HS_GO     = 2'h2,
        CRT_HS_LAST   = 2'h3
    } crt_hs_type;

    // ========================================================================
    // Operation kinds
    // ========================================================================
    typedef enum logic [1:0]
    {
        CRT_OP_MOVE_FROM = 2'h0,
        CRT_OP_MOVE_TO   = 2'h1,
        CRT_OP_DBL_FROM  = 2'h2,
        CRT_OP_DBL_TO    = 2'h3
    } crt_op_type;

    // ========================================================================
    // Sequencer states, Gray coded along the usual path
    // ========================================================================
    typedef enum logic [2:0]
    {
        CRT_ST_IDLE   = 3'h0,
        CRT_ST_WAIT   = 3'h1,
        CRT_ST_XFER1  = 3'h3,
        CRT_ST_XFER2  = 3'h2,
        CRT_ST_UNDEF  = 3'h6,
        CRT_ST_SKIP   = 3'h7
    } crt_state_type;

    // Bus cycle encodings: {no_request, sequential}
    localparam logic [1:0] CRT_CYC_N = 2'h0;
    localparam logic [1:0] CRT_CYC_S = 2'h1;
    localparam logic [1:0] CRT_CYC_I = 2'h2;
    localparam logic [1:0] CRT_CYC_C = 2'h3;

    // Undefined instruction vector and following fetches
    localparam logic [31:0] CRT_UNDEF_VEC  = 32'h0000_0004;
    localparam logic [31:0] CRT_FETCH_STEP = 32'h0000_0004;
    localparam logic [1:0]  CRT_UNDEF_FETCHES = 2'h3;

    // Reset values
    localparam logic [31:0] CRT_RST_ADDR = 32'h0000_0000;
    localparam logic [31:0] CRT_RST_DATA = 32'h0000_0000;

    // Instruction request carried into the sequencer
    typedef struct packed
    {
        logic        valid;   // Instruction issued this cycle
        crt_op_type  op;      // Transfer kind
        logic        cond_ok; // Condition code passed
        logic [3:0]  rd;      // First core register
        logic [3:0]  rn;      // Second core register
        logic [31:0] pc;      // Fetch address held while busy
    } crt_req_type;

    // Register write-back toward the core register file
    typedef struct packed
    {
        logic        we;
        logic [3:0]  idx;
        logic [31:0] data;
    } crt_wb_type;

endpackage

// >>> verilog/crt_beat_cnt.sv
// Two-beat coprocessor data-cycle counter.
// Restarted at each double transfer's first data cycle.
`timescale 1ns/10ps
`default_nettype none
module crt_beat_cnt
    import crt_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic ce,
    input  wire logic start,
    input  wire logic step,
    output logic      second
);

    // ========================================================================
    // Beat tracking
    // ========================================================================
    // Marks the second data cycle of a double transfer
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            second <= 1'b0;
        else if (ce)
        begin
            if (start)
                second <= 1'b0;
            else if (step)
                second <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// >>> verilog/crt_seq.sv
// Core-side sequencer for coprocessor register transfers.
// Assumes the core supplies decoded instruction fields and register values,
// and an attached coprocessor answering on two synchronous handshakes.
`timescale 1ns/10ps
`default_nettype none
module crt_seq
    import crt_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        ARST_N,
    input  wire logic        CLK_EN,
    input  wire crt_req_type REQ,
    input  wire logic        STD_STATE,
    input  wire logic        IRQ_TAKEN,
    input  wire logic [31:0] RD_VALUE,
    input  wire logic [31:0] RN_VALUE,
    input  wire logic [31:0] READ_DATA,
    input  wire crt_hs_type  CP_HANDSHAKE_DECODE,
    input  wire crt_hs_type  CP_HANDSHAKE_EXECUTE,
    output logic [31:0]      FETCH_ADDR_BUS,
    output logic             FETCHED_OPCODE_BUS_NO_REQUEST,
    output logic             FETCHED_OPCODE_BUS_SEQUENTIAL,
    output logic             LSU_NO_REQUEST,
    output logic             LSU_SEQUENTIAL,
    output logic [31:0]      WRITE_DATA,
    output logic             COND_PASS,
    output logic             LATE_ABORT_FLAG,
    output crt_wb_type       WRITE_BACK,
    output logic             UNDEF_TRAP,
    output logic             BUSY
);

    // ========================================================================
    // State
    // ========================================================================
    crt_state_type state;        // Sequencer state
    crt_state_type next_state;   // Following state
    crt_op_type    op;           // Latched transfer kind
    logic [3:0]    rd;           // Latched first register
    logic [3:0]    rn;           // Latched second register
    logic [31:0]   hold_pc;      // Fetch address held during the transfer
    logic [1:0]    undef_cnt;    // Vector fetches left
    logic          second;       // Second data cycle marker
    logic          beat_start;   // First data cycle begins
    logic          is_double;    // Double transfer kind
    logic [1:0]    next_icyc;    // Instruction cycle type
    logic [1:0]    next_dcyc;    // Data cycle type
    logic [31:0]   next_ia;      // Next fetch address
    logic          next_pass;    // Next condition-pass
    logic          start_ok;     // Transfer may start
    logic          tail;         // Cycle after XFER2

    assign is_double = (op == CRT_OP_DBL_FROM) || (op == CRT_OP_DBL_TO);
    // Only the standard instruction state starts a sequence
    assign start_ok  = REQ.valid && STD_STATE;

    // Tracks the second data cycle of double transfers
    crt_beat_cnt u_beat
    (
        .clk    (CLOCK),
        .arst_n (ARST_N),
        .ce     (CLK_EN),
        .start  (beat_start),
        .step   (state == CRT_ST_XFER1),
        .second (second)
    );

    // ========================================================================
    // Next-state and bus cycle selection
    // ========================================================================
    always_comb
    begin
        next_state = state;
        next_icyc  = CRT_CYC_I;
        next_dcyc  = CRT_CYC_I;
        next_ia    = hold_pc;
        next_pass  = 1'b1;
        beat_start = 1'b0;
        case (state)
            CRT_ST_IDLE:
            begin
                next_icyc = CRT_CYC_S;
                next_ia   = REQ.pc;
                if (start_ok && !REQ.cond_ok)
                begin
                    // Skipped: one sequential fetch, data side idle
                    next_state = CRT_ST_SKIP;
                    next_pass  = 1'b0;
                end
                else if (start_ok)
                begin
                    case (CP_HANDSHAKE_DECODE)
                        CRT_HS_LAST:
                        begin
                            // Single transfer goes straight to its C cycle
                            next_state = CRT_ST_XFER2;
                            next_dcyc  = CRT_CYC_C;
                        end
                        CRT_HS_GO:
                        begin
                            next_state = CRT_ST_XFER1;
                            next_icyc  = CRT_CYC_I;
                            next_dcyc  = CRT_CYC_C;
                            beat_start = 1'b1;
                        end
                        CRT_HS_WAIT:
                        begin
                            next_state = CRT_ST_WAIT;
                            next_icyc  = CRT_CYC_I;
                        end
                        default:
                        begin
                            // Absent in decode traps to the vector
                            next_state = CRT_ST_UNDEF;
                            next_icyc  = CRT_CYC_I;
                        end
                    endcase
                end
            end
            CRT_ST_WAIT:
            begin
                // Busy-wait: internal cycles, fetch address held
                if (IRQ_TAKEN)
                begin
                    next_state = CRT_ST_IDLE;
                    next_icyc  = CRT_CYC_S;
                end
                else
                begin
                    case (CP_HANDSHAKE_EXECUTE)
                        CRT_HS_LAST:
                        begin
                            next_state = CRT_ST_XFER2;
                            next_icyc  = is_double ? CRT_CYC_I : CRT_CYC_S;
                            next_dcyc  = CRT_CYC_C;
                        end
                        CRT_HS_GO:
                        begin
                            next_state = CRT_ST_XFER1;
                            next_dcyc  = CRT_CYC_C;
                            beat_start = 1'b1;
                        end
                        CRT_HS_WAIT:
                            next_pass = 1'b0;
                        default:
                        begin
                            next_state = CRT_ST_UNDEF;
                            next_pass  = 1'b0;
                            next_icyc  = CRT_CYC_N;
                            next_ia    = CRT_UNDEF_VEC;
                        end
                    endcase
                end
            end
            CRT_ST_XFER1:
            begin
                // Second C cycle ends the double transfer
                next_state = CRT_ST_XFER2;
                next_icyc  = CRT_CYC_S;
                next_dcyc  = CRT_CYC_C;
            end
            CRT_ST_XFER2:
            begin
                next_state = CRT_ST_IDLE;
                next_icyc  = CRT_CYC_S;
                next_ia    = REQ.pc;
            end
            CRT_ST_UNDEF:
            begin
                // Vector fetch then two sequential fetches
                next_pass = 1'b0;
                next_icyc = (undef_cnt == CRT_UNDEF_FETCHES) ? CRT_CYC_N : CRT_CYC_S;
                next_ia   = CRT_UNDEF_VEC
                          + (32'(CRT_UNDEF_FETCHES - undef_cnt) * CRT_FETCH_STEP);
                if (undef_cnt == 2'h1)
                    next_state = CRT_ST_IDLE;
            end
            CRT_ST_SKIP:
            begin
                next_state = CRT_ST_IDLE;
                next_icyc  = CRT_CYC_S;
                next_ia    = REQ.pc;
            end
            default:
                next_state = CRT_ST_IDLE;
        endcase
    end

    // ========================================================================
    // Sequencer state register
    // ========================================================================
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
            state <= CRT_ST_IDLE;
        else if (CLK_EN)
            state <= next_state;
    end

    // Latches the instruction fields when a transfer starts
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            op      <= CRT_OP_MOVE_FROM;
            rd      <= 4'h0;
            rn      <= 4'h0;
            hold_pc <= CRT_RST_ADDR;
        end
        else if (CLK_EN && state == CRT_ST_IDLE && start_ok)
        begin
            op      <= REQ.op;
            rd      <= REQ.rd;
            rn      <= REQ.rn;
            hold_pc <= REQ.pc;
        end
    end

    // Counts the vector fetches of the undefined trap
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
            undef_cnt <= 2'h0;
        else if (CLK_EN)
        begin
            if (next_state == CRT_ST_UNDEF && state != CRT_ST_UNDEF)
                undef_cnt <= CRT_UNDEF_FETCHES - 2'(state == CRT_ST_WAIT);
            else if (state == CRT_ST_UNDEF)
                undef_cnt <= undef_cnt - 2'h1;
        end
    end

    // ========================================================================
    // Bus outputs, all registered
    // ========================================================================
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            FETCH_ADDR_BUS   <= CRT_RST_ADDR;
            FETCHED_OPCODE_BUS_NO_REQUEST <= CRT_CYC_I[1];
            FETCHED_OPCODE_BUS_SEQUENTIAL <= CRT_CYC_I[0];
            LSU_NO_REQUEST   <= CRT_CYC_I[1];
            LSU_SEQUENTIAL   <= CRT_CYC_I[0];
            COND_PASS        <= 1'b0;
            LATE_ABORT_FLAG  <= 1'b0;
            UNDEF_TRAP       <= 1'b0;
            BUSY             <= 1'b0;
            tail             <= 1'b0;
        end
        else if (CLK_EN)
        begin
            FETCH_ADDR_BUS   <= next_ia;
            FETCHED_OPCODE_BUS_NO_REQUEST <= next_icyc[1];
            FETCHED_OPCODE_BUS_SEQUENTIAL <= next_icyc[0];
            LSU_NO_REQUEST   <= next_dcyc[1];
            LSU_SEQUENTIAL   <= next_dcyc[0];
            COND_PASS        <= next_pass;
            LATE_ABORT_FLAG  <= 1'b0;
            UNDEF_TRAP       <= (next_state == CRT_ST_UNDEF) && (state != CRT_ST_UNDEF);
            BUSY             <= (next_state != CRT_ST_IDLE);
            tail             <= (state == CRT_ST_XFER2);
        end
    end

    // Write data: first register, then second register for doubles
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
            WRITE_DATA <= CRT_RST_DATA;
        else if (CLK_EN)
        begin
            if (next_state == CRT_ST_XFER2 && state == CRT_ST_XFER1)
                WRITE_DATA <= RD_VALUE;
            else if (next_state == CRT_ST_XFER2)
                WRITE_DATA <= RD_VALUE;
            else if (state == CRT_ST_XFER2 && is_double)
                WRITE_DATA <= RN_VALUE;
        end
    end

    // Read data taken as a load, a cycle after each C cycle
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
            WRITE_BACK <= '0;
        else if (CLK_EN)
        begin
            WRITE_BACK.we <= 1'b0;
            if (state == CRT_ST_XFER2 && second && op == CRT_OP_DBL_FROM)
            begin
                WRITE_BACK <= '{we: 1'b1, idx: rd, data: READ_DATA};
            end
            else if (tail && (op == CRT_OP_MOVE_FROM || op == CRT_OP_DBL_FROM))
            begin
                // Word in the cycle after the last C cycle
                WRITE_BACK <= '{we: 1'b1,
                               idx: (op == CRT_OP_DBL_FROM) ? rn : rd,
                               data: READ_DATA};
            end
        end
    end

    // ========================================================================
    // Checks
    // ========================================================================
    property p_skip_one;
        @(posedge CLOCK) disable iff (!ARST_N)
        (state == CRT_ST_SKIP && CLK_EN) |=> (state == CRT_ST_IDLE);
    endproperty
    a_skip_one: assert property (p_skip_one) else $error("skip not one cycle");

    property p_wait_hold;
        @(posedge CLOCK) disable iff (!ARST_N)
        (state == CRT_ST_WAIT && CLK_EN && CP_HANDSHAKE_EXECUTE == CRT_HS_WAIT && !IRQ_TAKEN)
        |=> (LSU_NO_REQUEST && !LSU_SEQUENTIAL && FETCHED_OPCODE_BUS_NO_REQUEST && !COND_PASS);
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("wait not idle");

    property p_undef_vec;
        @(posedge CLOCK) disable iff (!ARST_N)
        (UNDEF_TRAP && CLK_EN) |-> ##[0:1] (FETCH_ADDR_BUS == CRT_UNDEF_VEC && !FETCHED_OPCODE_BUS_NO_REQUEST
                                     && !FETCHED_OPCODE_BUS_SEQUENTIAL);
    endproperty
    a_undef_vec: assert property (p_undef_vec) else $error("vector fetch wrong");

    property p_state_gate;
        @(posedge CLOCK) disable iff (!ARST_N)
        (state == CRT_ST_IDLE && CLK_EN && REQ.valid && !STD_STATE) |=> (state == CRT_ST_IDLE);
    endproperty
    a_state_gate: assert property (p_state_gate) else $error("started outside state");

    property p_double_two;
        @(posedge CLOCK) disable iff (!ARST_N)
        (state == CRT_ST_XFER1 && CLK_EN) |=> (state == CRT_ST_XFER2 && LSU_NO_REQUEST
                                                && LSU_SEQUENTIAL);
    endproperty
    a_double_two: assert property (p_double_two) else $error("double not two cycles");

    property p_undef_pass;
        @(posedge CLOCK) disable iff (!ARST_N)
        (state == CRT_ST_UNDEF && CLK_EN) |=> !COND_PASS;
    endproperty
    a_undef_pass: assert property (p_undef_pass) else $error("pass high in trap");

    property p_no_late;
        @(posedge CLOCK) disable iff (!ARST_N)
        BUSY |-> !LATE_ABORT_FLAG;
    endproperty
    a_no_late: assert property (p_no_late) else $error("late abort raised");

    property p_rn_second;
        @(posedge CLOCK) disable iff (!ARST_N)
        (state == CRT_ST_XFER2 && op == CRT_OP_DBL_TO && CLK_EN)
        |=> (WRITE_DATA == $past(RN_VALUE));
    endproperty
    a_rn_second: assert property (p_rn_second) else $error("second word wrong");

endmodule
`default_nettype wire

// >>> bench/crt_cp_model.sv
// Behavioural coprocessor that answers the transfer sequencer.
// Assumes start pulses with each request; script inputs held.
`timescale 1ns/10ps
`default_nettype none
module crt_cp_model
    import crt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        start,
    input  wire logic        drop,
    input  wire logic        dbl,
    input  wire logic [3:0]  waits,
    input  wire crt_hs_type  fin,
    input  wire logic [31:0] word0,
    input  wire logic [31:0] word1,
    input  wire logic        lsu_no_request,
    input  wire logic        lsu_sequential,
    output crt_hs_type       hs_decode,
    output crt_hs_type       hs_execute,
    output logic [31:0]      read_data
);
    // ========================================================================
    // Script position
    // ========================================================================
    logic        active; // Handling the current instruction
    logic [4:0]  k;      // Cycles since the instruction was taken
    logic        beat;   // Second word is next
    logic [31:0] last;   // Last word shown on the read bus
    logic        c_cyc;  // Sequencer runs a coprocessor data cycle
    logic        c_dly;  // Data cycle one cycle ago

    assign c_cyc = ({lsu_no_request, lsu_sequential} == CRT_CYC_C);

    // Script walk; drop abandons a wait
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            active <= 1'b0;
            k      <= 5'h0;
        end
        else if (start)
        begin
            active <= 1'b1;
            k      <= 5'h1;
        end
        else if (drop || k >= {1'b0, waits} + 5'(dbl))
            active <= 1'b0;
        else
            k <= k + 5'h1;
    end

    // Handshake answers, Absent whenever idle
    always_comb
    begin
        hs_decode  = CRT_HS_ABSENT;
        hs_execute = CRT_HS_ABSENT;
        if (start)
            hs_decode = (waits != 4'h0) ? CRT_HS_WAIT : (dbl ? CRT_HS_GO : fin);
        if (active && k < {1'b0, waits})
            hs_execute = CRT_HS_WAIT;
        else if (active && k == {1'b0, waits})
            hs_execute = dbl ? CRT_HS_GO : fin;
        else if (active && dbl && k == {1'b0, waits} + 5'h1)
            hs_execute = CRT_HS_LAST;
    end

    // Words a cycle after data cycles; else the last word shown, inverted
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            beat  <= 1'b0;
            last  <= 32'h0000_0000;
            c_dly <= 1'b0;
        end
        else
        begin
            c_dly <= c_cyc;
            if (start)
                beat <= 1'b0;
            else if (c_dly)
            begin
                beat <= 1'b1;
                last <= read_data;
            end
        end
    end

    assign read_data = c_dly ? (beat ? word1 : word0) : ~last;
endmodule
`default_nettype wire

// >>> bench/crt_seq_test.sv
// Self-checking bench for the coprocessor register transfer sequencer.
// Assumes the behavioural coprocessor model drives handshakes and read data.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
    begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR %0t: got %h exp %h", $time, (got), (exp)); end end
module crt_seq_test
    import crt_pkg::*;
    ;
    typedef struct
    {
        crt_op_type op;
        logic [3:0] w;
        crt_hs_type fin;
        int         n_wb;
        int         n_trap;
    } crt_row_type;

    localparam logic [31:0] PC  = 32'h0000_1000;
    localparam logic [31:0] RDV = 32'hA5A5_0001;
    localparam logic [31:0] RNV = 32'h5A5A_0002;
    localparam logic [31:0] W0  = 32'hC0DE_0011;
    localparam logic [31:0] W1  = 32'hC0DE_0022;
    localparam crt_wb_type  WB0 = '{1'b1, 4'h3, W0};
    localparam crt_wb_type  WB1 = '{1'b1, 4'h9, W1};

    logic        CLOCK;
    logic        ARST_N;
    logic        CLK_EN;
    crt_req_type REQ;
    logic        STD_STATE;
    logic        IRQ_TAKEN;
    logic        start;
    logic        drop;
    logic        dbl;
    logic [3:0]  waits;
    crt_hs_type  fin_hs;
    crt_hs_type  hs_dec;
    crt_hs_type  hs_exe;
    logic [31:0] read_data;
    logic [31:0] FETCH_ADDR_BUS;
    logic        FETCHED_OPCODE_BUS_NO_REQUEST;
    logic        FETCHED_OPCODE_BUS_SEQUENTIAL;
    logic        LSU_NO_REQUEST;
    logic        LSU_SEQUENTIAL;
    logic [31:0] WRITE_DATA;
    logic        COND_PASS;
    logic        LATE_ABORT_FLAG;
    crt_wb_type  WRITE_BACK;
    logic        UNDEF_TRAP;
    logic        BUSY;
    int          fail_count = 0;
    int          total_checks = 0;
    int          cycles = 0;

    // Kind, waits, answer, write-backs, traps
    crt_row_type rows [10] = '{
        '{CRT_OP_MOVE_FROM, 4'h0, CRT_HS_LAST, 1, 0},
        '{CRT_OP_MOVE_FROM, 4'h2, CRT_HS_LAST, 1, 0},
        '{CRT_OP_MOVE_TO, 4'h0, CRT_HS_LAST, 0, 0},
        '{CRT_OP_MOVE_TO, 4'h3, CRT_HS_LAST, 0, 0},
        '{CRT_OP_DBL_FROM, 4'h0, CRT_HS_LAST, 2, 0},
        '{CRT_OP_DBL_FROM, 4'h2, CRT_HS_LAST, 2, 0},
        '{CRT_OP_DBL_TO, 4'h0, CRT_HS_LAST, 0, 0},
        '{CRT_OP_DBL_TO, 4'h1, CRT_HS_LAST, 0, 0},
        '{CRT_OP_MOVE_FROM, 4'h0, CRT_HS_ABSENT, 0, 1},
        '{CRT_OP_MOVE_TO, 4'h3, CRT_HS_ABSENT, 0, 1}
    };

    crt_seq u_dut
    (
        .CLOCK(CLOCK), .ARST_N(ARST_N), .CLK_EN(CLK_EN), .REQ(REQ),
        .STD_STATE(STD_STATE), .IRQ_TAKEN(IRQ_TAKEN), .RD_VALUE(RDV),
        .RN_VALUE(RNV), .READ_DATA(read_data), .CP_HANDSHAKE_DECODE(hs_dec),
        .CP_HANDSHAKE_EXECUTE(hs_exe), .FETCH_ADDR_BUS(FETCH_ADDR_BUS),
        .FETCHED_OPCODE_BUS_NO_REQUEST(FETCHED_OPCODE_BUS_NO_REQUEST), .FETCHED_OPCODE_BUS_SEQUENTIAL(FETCHED_OPCODE_BUS_SEQUENTIAL),
        .LSU_NO_REQUEST(LSU_NO_REQUEST), .LSU_SEQUENTIAL(LSU_SEQUENTIAL),
        .WRITE_DATA(WRITE_DATA), .COND_PASS(COND_PASS),
        .LATE_ABORT_FLAG(LATE_ABORT_FLAG), .WRITE_BACK(WRITE_BACK),
        .UNDEF_TRAP(UNDEF_TRAP), .BUSY(BUSY)
    );

    crt_cp_model u_cp
    (
        .clk(CLOCK), .arst_n(ARST_N), .start(start), .drop(drop), .dbl(dbl),
        .waits(waits), .fin(fin_hs), .word0(W0), .word1(W1),
        .lsu_no_request(LSU_NO_REQUEST), .lsu_sequential(LSU_SEQUENTIAL),
        .hs_decode(hs_dec), .hs_execute(hs_exe), .read_data(read_data)
    );

    // ========================================================================
    // Clock, hang guard and shared tasks
    // ========================================================================
    initial
    begin
        CLOCK = 1'b0;
        forever #4 CLOCK = ~CLOCK;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Hang guard
    always @(posedge CLOCK)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            $display("ERROR %0t: timeout", $time);
            results();
        end
    end

    task automatic tick();
        @(posedge CLOCK);
        #1;
    endtask

    task automatic chk_cyc(input logic [1:0] ic, input logic [1:0] dc);
        `CHK({FETCHED_OPCODE_BUS_NO_REQUEST, FETCHED_OPCODE_BUS_SEQUENTIAL}, ic)
        `CHK({LSU_NO_REQUEST, LSU_SEQUENTIAL}, dc)
    endtask

    // One request for one edge
    task automatic issue(input crt_op_type op, input logic [3:0] w, input crt_hs_type fin,
                         input logic cond);
        REQ    = '{1'b1, op, cond, 4'h3, 4'h9, PC};
        dbl    = op[1];
        waits  = w;
        fin_hs = fin;
        start  = cond;
        tick();
        REQ.valid = 1'b0;
        start     = 1'b0;
    endtask

    // Runs and checks one row
    task automatic xfer(input crt_row_type r);
        int   wb;
        int   trap;
        int   b;
        logic d;
        wb   = 0;
        trap = 0;
        d    = r.op[1];
        b    = (r.w == 4'h0) ? 1 : int'(r.w);
        issue(r.op, r.w, r.fin, 1'b1);
        for (int k = 1; k <= int'(r.w) + 6; k++)
        begin
            `CHK(LATE_ABORT_FLAG, 1'b0)
            if (r.fin == CRT_HS_ABSENT)
            begin
                if (k >= 2 && k <= b + 3)
                    `CHK(COND_PASS, 1'b0)
                if (k <= b)
                    chk_cyc(CRT_CYC_I, CRT_CYC_I);
                else if (k <= b + 3)
                begin
                    `CHK(FETCH_ADDR_BUS, 32'(k - b) << 2)
                    chk_cyc((k == b + 1) ? CRT_CYC_N : CRT_CYC_S, CRT_CYC_I);
                end
            end
            else if (k <= int'(r.w))
            begin
                chk_cyc(CRT_CYC_I, CRT_CYC_I);
                `CHK(FETCH_ADDR_BUS, PC)
                `CHK(COND_PASS, k == 1)
            end
            else if (k == int'(r.w) + 1)
            begin
                chk_cyc(d ? CRT_CYC_I : CRT_CYC_S, CRT_CYC_C);
                if (r.op == CRT_OP_MOVE_TO)
                    `CHK(WRITE_DATA, RDV)
            end
            else if (d && k == int'(r.w) + 2)
            begin
                chk_cyc(CRT_CYC_S, CRT_CYC_C);
                if (r.op == CRT_OP_DBL_TO)
                    `CHK(WRITE_DATA, RDV)
            end
            else if (d && k == int'(r.w) + 3 && r.op == CRT_OP_DBL_TO)
                `CHK(WRITE_DATA, RNV)
            if (WRITE_BACK.we === 1'b1)
            begin
                `CHK(WRITE_BACK, (wb == 0) ? WB0 : WB1)
                wb++;
            end
            if (UNDEF_TRAP === 1'b1)
                trap++;
            tick();
        end
        `CHK(wb, r.n_wb)
        `CHK(trap, r.n_trap)
        `CHK(BUSY, 1'b0)
    endtask

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial
    begin
        CLK_EN    = 1'b1;
        ARST_N    = 1'b0;
        REQ       = '0;
        STD_STATE = 1'b1;
        IRQ_TAKEN = 1'b0;
        start     = 1'b0;
        drop      = 1'b0;
        dbl       = 1'b0;
        waits     = 4'h0;
        fin_hs    = CRT_HS_LAST;
        repeat (6) @(posedge CLOCK);
        #1;
        ARST_N = 1'b1;
        `CHK(LATE_ABORT_FLAG, 1'b0)
        `CHK(WRITE_BACK.we, 1'b0)
        $display("test reset done");
        // Failed condition, then a transfer
        issue(CRT_OP_MOVE_TO, 4'h0, CRT_HS_LAST, 1'b0);
        chk_cyc(CRT_CYC_S, CRT_CYC_I);
        `CHK(UNDEF_TRAP, 1'b0)
        tick();
        xfer(rows[0]);
        $display("test skip done");
        foreach (rows[i])
            xfer(rows[i]);
        $display("test rows done");
        // Outside the 32-bit state
        STD_STATE = 1'b0;
        issue(CRT_OP_MOVE_FROM, 4'h0, CRT_HS_LAST, 1'b1);
        for (int k = 0; k < 3; k++)
        begin
            `CHK({LSU_NO_REQUEST, LSU_SEQUENTIAL}, CRT_CYC_I)
            `CHK(WRITE_BACK.we, 1'b0)
            tick();
        end
        STD_STATE = 1'b1;
        $display("test state done");
        // Interrupt abandons a long wait
        issue(CRT_OP_MOVE_TO, 4'h8, CRT_HS_LAST, 1'b1);
        tick();
        `CHK(BUSY, 1'b1)
        IRQ_TAKEN = 1'b1;
        drop      = 1'b1;
        tick();
        IRQ_TAKEN = 1'b0;
        drop      = 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            `CHK({LSU_NO_REQUEST, LSU_SEQUENTIAL}, CRT_CYC_I)
            tick();
        end
        `CHK(BUSY, 1'b0)
        $display("test interrupt done");
        results();
    end
endmodule
`default_nettype wire
